// file: verilog/bmls_pkg.sv
// Constants shared by the burst level select and entry block
package bmls_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int CLK_MHZ        = 25;
	localparam int SEL_TIME_NS    = 2000;
	localparam int SEL_CYCLES     = (SEL_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int BLANK_TIME_MS  = 20;
	localparam int BLANK_CYCLES   = BLANK_TIME_MS * CLK_MHZ * 1000;

	// ****************************************************************
	// Burst levels and current limit codes
	// ****************************************************************
	localparam logic [1:0] LVL_1     = 2'h1;
	localparam logic [1:0] LVL_2     = 2'h2;
	localparam logic [1:0] LVL_3     = 2'h3;
	localparam logic [1:0] LIM_FULL  = 2'h0;

	// ****************************************************************
	// Register offsets (byte addresses)
	// ****************************************************************
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_IRQ_ST = 4'h8;
	localparam logic [3:0] OFS_IRQ_MK = 4'hC;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int CTRL_BURST_EN   = 0;
	localparam int ST_LEVEL_LO     = 0;
	localparam int ST_LATCH        = 2;
	localparam int ST_FLAG         = 3;
	localparam int ST_BIAS         = 4;
	localparam int ST_SEL_EN       = 5;
	localparam int ST_CURVE        = 6;
	localparam int IRQ_ENTER       = 0;
	localparam int IRQ_EXIT        = 1;
	localparam int IRQ_LATCHED     = 2;
	localparam logic       CTRL_RST = 1'h1;
	localparam logic [2:0] MASK_RST = 3'h0;

	// Burst control states
	typedef enum logic [1:0] {
		BMLS_NORMAL,
		BMLS_SLEEP,
		BMLS_ACTIVE
	} bmls_state_t;

endpackage : bmls_pkg

// file: verilog/bmls_sync.sv
// Two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module bmls_sync
	import bmls_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule : bmls_sync

// file: verilog/bmls_tmr.sv
// Saturating run/clear counter used for the select timer and blanking
`timescale 1ns/1ps
module bmls_tmr
	import bmls_pkg::*;
#(
	parameter int LIMIT = 50
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic run_i,
	output logic      done_o
);

	localparam int W = $clog2(LIMIT + 1);
	localparam logic [W-1:0] LIM = W'(LIMIT);

	logic [W-1:0] cnt_q;

	// Counts while run is high, held at zero otherwise
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt_q <= '0;
		end else if (cnt_q != LIM) begin
			cnt_q <= cnt_q + W'(1);
		end
	end

	assign done_o = (cnt_q == LIM);

	chk_tmr_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		!run_i |=> cnt_q == '0)
		else $error("counter not cleared while stopped");

endmodule : bmls_tmr

// file: verilog/bmls_top.sv
// Burst level select, burst entry and burst control with Avalon registers
// Function
// - Pick compensation curve from switching time range
// - Decode feedback into burst levels one to three
// - Entry threshold select follows latched level
// - Burst current limit select follows latched level
// - Reference not good holds level latch cleared
// - Latch clear and off: select current on
// - At turn-on sample level and set latch
// - Latched level only changes at a new turn-on after reference loss
// - Two microsecond timer then reconnect feedback resistor
// - Blanking counter zero unless feedback below threshold
// - Enter burst after 20 ms blanking
// - Burst entry sets flag and cuts bias
// - Compensation curve applies in burst too
// - Blanking guards burst entry against short dips
// - Wake comparator restores bias, sleep comparator cuts
// - Above 4.0V leave burst, full limit
`timescale 1ns/1ps
module bmls_top
	import bmls_pkg::*;
#(
	parameter int BLANK_LIMIT = BLANK_CYCLES
) (
	input  wire logic        CLOCK_I,
	input  wire logic        RST_I,
	input  wire logic        REF_GOOD_I,
	input  wire logic        VCC_ON_I,
	input  wire logic        FB_ABOVE_REF1_I,
	input  wire logic        FB_ABOVE_4V0_I,
	input  wire logic        BURST_ENTRY_COMPARATOR_I,
	input  wire logic        BURST_WAKE_COMPARATOR_I,
	input  wire logic        BURST_SLEEP_COMPARATOR_I,
	input  wire logic        TON_LONG_I,
	input  wire logic [3:0]  AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	output logic      [31:0] AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O,
	output logic      [1:0]  LEVEL_O,
	output logic      [1:0]  BURST_ENTRY_THRESHOLD_O,
	output logic      [1:0]  CS_LIMIT_SEL_O,
	output logic             SEL_CURRENT_EN_O,
	output logic             FB_RES_CONNECT_O,
	output logic             BIAS_EN_O,
	output logic             BURST_FLAG_O,
	output logic             COMP_CURVE_O,
	output logic             IRQ_O
);

	// ****************************************************************
	// Input synchronisation
	// ****************************************************************
	logic [7:0]  raw_in;
	logic [7:0]  syn;
	logic        ref_good_s;
	logic        vcc_on_s;
	logic        above_ref1_s;
	logic        above_4v0_s;
	logic        entry_low_s;
	logic        wake_s;
	logic        sleep_s;
	logic        ton_long_s;

	assign raw_in = {TON_LONG_I, BURST_SLEEP_COMPARATOR_I,
		BURST_WAKE_COMPARATOR_I, BURST_ENTRY_COMPARATOR_I,
		FB_ABOVE_4V0_I, FB_ABOVE_REF1_I, VCC_ON_I, REF_GOOD_I};

	// Every analog indication passes two flops first
	bmls_sync #(.WIDTH(8)) u_sync (
		.clk_i   (CLOCK_I),
		.rst_i   (RST_I),
		.async_i (raw_in),
		.sync_o  (syn)
	);

	assign ref_good_s   = syn[0];
	assign vcc_on_s     = syn[1];
	assign above_ref1_s = syn[2];
	assign above_4v0_s  = syn[3];
	assign entry_low_s  = syn[4];
	assign wake_s       = syn[5];
	assign sleep_s      = syn[6];
	assign ton_long_s   = syn[7];

	// Decode the two level comparators into a burst level
	function automatic logic [1:0] lvl_decode(input logic hi,
			input logic mid);
		if (hi) begin
			lvl_decode = LVL_3;
		end else if (mid) begin
			lvl_decode = LVL_2;
		end else begin
			lvl_decode = LVL_1;
		end
	endfunction : lvl_decode

	// ****************************************************************
	// Level detection latch and select current
	// ****************************************************************
	logic        vcc_on_d_q;
	logic        vcc_rise;
	logic        latch_q;
	logic [1:0]  level_q;
	logic        sel_en_q;
	logic        fb_res_q;
	logic        sel_done;

	assign vcc_rise = vcc_on_s && !vcc_on_d_q;

	// Turn-on edge detector
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			vcc_on_d_q <= 1'h0;
		end else begin
			vcc_on_d_q <= vcc_on_s;
		end
	end

	// Level is caught at each turn-on with the latch clear and then frozen
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			latch_q <= 1'h0;
			level_q <= LVL_1;
		end else if (!ref_good_s) begin
			latch_q <= 1'h0;
		end else if (vcc_rise && !latch_q) begin
			latch_q <= 1'h1;
			level_q <= lvl_decode(above_4v0_s, above_ref1_s);
		end
	end

	// Select current timer starts with the latch
	bmls_tmr #(.LIMIT(SEL_CYCLES)) u_sel_tmr (
		.clk_i  (CLOCK_I),
		.rst_i  (RST_I),
		.run_i  (latch_q && sel_en_q),
		.done_o (sel_done)
	);

	// Select current replaces the feedback resistor until timer ends
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			sel_en_q <= 1'h0;
			fb_res_q <= 1'h1;
		end else if (!latch_q && !vcc_on_s) begin
			sel_en_q <= 1'h1;
			fb_res_q <= 1'h0;
		end else if (sel_done) begin
			sel_en_q <= 1'h0;
			fb_res_q <= 1'h1;
		end
	end

	// ****************************************************************
	// Blanking and burst control
	// ****************************************************************
	bmls_state_t state_q;
	bmls_state_t state_d;
	logic        burst_en_q;
	logic        blank_done;
	logic        blank_run;
	logic        enter;
	logic        leave;

	// Counter only runs in normal mode with feedback below threshold
	assign blank_run = (state_q == BMLS_NORMAL) && entry_low_s
		&& burst_en_q && latch_q;

	bmls_tmr #(.LIMIT(BLANK_LIMIT)) u_blank (
		.clk_i  (CLOCK_I),
		.rst_i  (RST_I),
		.run_i  (blank_run),
		.done_o (blank_done)
	);

	assign enter = blank_run && blank_done;
	assign leave = (state_q != BMLS_NORMAL) && above_4v0_s;

	// Next burst state, exit has priority over wake
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			BMLS_NORMAL: begin
				if (enter) begin
					state_d = BMLS_SLEEP;
				end
			end
			BMLS_SLEEP: begin
				if (leave) begin
					state_d = BMLS_NORMAL;
				end else if (wake_s) begin
					state_d = BMLS_ACTIVE;
				end
			end
			BMLS_ACTIVE: begin
				if (leave) begin
					state_d = BMLS_NORMAL;
				end else if (sleep_s) begin
					state_d = BMLS_SLEEP;
				end
			end
		endcase
	end

	// Burst state register
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			state_q <= BMLS_NORMAL;
		end else begin
			state_q <= state_d;
		end
	end

	// Flag, bias and limit outputs follow the next state
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			BURST_FLAG_O   <= 1'h0;
			BIAS_EN_O      <= 1'h1;
			CS_LIMIT_SEL_O <= LIM_FULL;
		end else begin
			BURST_FLAG_O   <= (state_d != BMLS_NORMAL);
			BIAS_EN_O      <= (state_d != BMLS_SLEEP);
			CS_LIMIT_SEL_O <= (state_d == BMLS_NORMAL) ? LIM_FULL
				: level_q;
		end
	end

	// Threshold selects, curve select and pin controls
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			LEVEL_O                 <= LVL_1;
			BURST_ENTRY_THRESHOLD_O <= LVL_1;
			COMP_CURVE_O            <= 1'h0;
			SEL_CURRENT_EN_O        <= 1'h0;
			FB_RES_CONNECT_O        <= 1'h1;
		end else begin
			LEVEL_O                 <= level_q;
			BURST_ENTRY_THRESHOLD_O <= level_q;
			COMP_CURVE_O            <= ton_long_s;
			SEL_CURRENT_EN_O        <= sel_en_q;
			FB_RES_CONNECT_O        <= fb_res_q;
		end
	end

	// ****************************************************************
	// Avalon-MM slave, one wait state per access
	// ****************************************************************
	logic [2:0]  irq_st_q;
	logic [2:0]  irq_mk_q;
	logic [2:0]  irq_set;
	logic        acc;
	logic        wr_go;

	assign acc   = AVS_READ_I || AVS_WRITE_I;
	assign wr_go = AVS_WRITE_I && !AVS_WAITREQUEST_O;

	// Waitrequest drops for one cycle, the cycle after a request
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			AVS_WAITREQUEST_O <= 1'h1;
		end else begin
			AVS_WAITREQUEST_O <= !(acc && AVS_WAITREQUEST_O);
		end
	end

	// Read data captured with the waitrequest release
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			AVS_READDATA_O <= 32'h0;
		end else if (AVS_READ_I && AVS_WAITREQUEST_O) begin
			unique case (AVS_ADDRESS_I)
				OFS_CTRL:   AVS_READDATA_O <= {31'h0, burst_en_q};
				OFS_STATUS: AVS_READDATA_O <= {25'h0, COMP_CURVE_O,
					sel_en_q, BIAS_EN_O, BURST_FLAG_O, latch_q, level_q};
				OFS_IRQ_ST: AVS_READDATA_O <= {29'h0, irq_st_q};
				OFS_IRQ_MK: AVS_READDATA_O <= {29'h0, irq_mk_q};
				default:    AVS_READDATA_O <= 32'h0;
			endcase
		end
	end

	// Control and mask registers
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			burst_en_q <= CTRL_RST;
			irq_mk_q   <= MASK_RST;
		end else if (wr_go && AVS_ADDRESS_I == OFS_CTRL) begin
			burst_en_q <= AVS_WRITEDATA_I[CTRL_BURST_EN];
		end else if (wr_go && AVS_ADDRESS_I == OFS_IRQ_MK) begin
			irq_mk_q <= AVS_WRITEDATA_I[2:0];
		end
	end

	// ****************************************************************
	// Interrupts: sticky events, write one to clear, set wins
	// ****************************************************************
	always_comb begin
		irq_set = 3'h0;
		irq_set[IRQ_ENTER]   = enter;
		irq_set[IRQ_EXIT]    = leave;
		irq_set[IRQ_LATCHED] = ref_good_s && vcc_rise && !latch_q;
	end

	// Status bits
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			irq_st_q <= 3'h0;
		end else if (wr_go && AVS_ADDRESS_I == OFS_IRQ_ST) begin
			irq_st_q <= (irq_st_q & ~AVS_WRITEDATA_I[2:0]) | irq_set;
		end else begin
			irq_st_q <= irq_st_q | irq_set;
		end
	end

	// Level interrupt output
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			IRQ_O <= 1'h0;
		end else begin
			IRQ_O <= |(irq_st_q & irq_mk_q);
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);

	chk_latch_held_clear: assert property (
		!ref_good_s |=> !latch_q)
		else $error("level latch set while reference not good");

	chk_select_current_on: assert property (
		!latch_q && !vcc_on_s && !$past(RST_I) |=> sel_en_q && !fb_res_q)
		else $error("select current not enabled before turn-on");

	chk_level_sampled: assert property (
		ref_good_s && vcc_rise && !latch_q |=> latch_q
		&& level_q == lvl_decode($past(above_4v0_s), $past(above_ref1_s)))
		else $error("level not sampled at turn-on");

	chk_level_frozen: assert property (
		latch_q && $past(latch_q) |-> $stable(level_q))
		else $error("latched level changed");

	chk_select_timer_end: assert property (
		$rose(latch_q) && sel_en_q ##1 ref_good_s[*1]
		|-> ##[48:52] !sel_en_q && fb_res_q)
		else $error("select current not released near two microseconds");

	chk_burst_entry: assert property (
		enter |=> state_q == BMLS_SLEEP ##1 BURST_FLAG_O && !BIAS_EN_O)
		else $error("burst not entered after blanking");

	chk_no_early_entry: assert property (
		state_q == BMLS_NORMAL && !entry_low_s |=> state_q == BMLS_NORMAL)
		else $error("burst entered with feedback above threshold");

	chk_wake_bias: assert property (
		state_q == BMLS_SLEEP && wake_s && !above_4v0_s |=> BIAS_EN_O)
		else $error("bias not restored on wake");

	chk_burst_exit: assert property (
		leave |=> !BURST_FLAG_O && CS_LIMIT_SEL_O == LIM_FULL)
		else $error("burst not left above exit level");

	chk_burst_limit: assert property (
		state_q != BMLS_NORMAL && !leave |=> CS_LIMIT_SEL_O == level_q)
		else $error("burst current limit does not follow level");

	chk_curve_select: assert property (
		1'b1 |=> COMP_CURVE_O == $past(ton_long_s))
		else $error("compensation curve not following time range");

endmodule : bmls_top

// file: tb/bmls_afe_model.sv
// Behavioural model of the supply and feedback comparator front end
`timescale 1ns/1ps
module bmls_afe_model (
	input  wire logic       clk_i,
	input  int              fb_mv_i,
	input  int              vcc_mv_i,
	input  wire logic [1:0] thr_sel_i,
	output logic            ref_good_o,
	output logic            vcc_on_o,
	output logic            above_ref1_o,
	output logic            above_4v0_o,
	output logic            entry_o,
	output logic            wake_o,
	output logic            sleep_o
);
	int thr_mv;

	// ****************************************************************
	// Threshold and comparators
	// ****************************************************************
	// Entry threshold in millivolts from the select code
	always_comb begin
		case (thr_sel_i)
			2'h2: thr_mv = 1610;
			2'h3: thr_mv = 1840;
			default: thr_mv = 1290;
		endcase
	end

	// Comparators change right after the clock edge, as bench drivers do
	always @(posedge clk_i) begin
		ref_good_o   <= vcc_mv_i > 8000;
		vcc_on_o     <= vcc_mv_i >= 17000;
		above_ref1_o <= fb_mv_i > 1800;
		above_4v0_o  <= fb_mv_i > 4000;
		entry_o      <= fb_mv_i < thr_mv;
		wake_o       <= fb_mv_i > 3500;
		sleep_o      <= fb_mv_i <= 3200;
	end
endmodule : bmls_afe_model

// file: tb/bmls_top_tb.sv
// Self-checking bench for the burst level select and entry block
`timescale 1ns/1ps
module bmls_top_tb;
	import bmls_pkg::*;
	localparam int BL = 20;
	logic        clk, rst, ton, rd_en, wr_en, waitreq, irq;
	logic        rg, von, fb1, fb4, ent, wak, slp;
	logic        sel, fbres, bias, flag, curve;
	logic [1:0]  lvl_o, thr, cs;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata, rv;
	int          fb_mv, vcc_mv, bad_count, tests_run;

	bmls_afe_model afe (.clk_i(clk), .fb_mv_i(fb_mv), .vcc_mv_i(vcc_mv),
		.thr_sel_i(thr), .ref_good_o(rg), .vcc_on_o(von),
		.above_ref1_o(fb1), .above_4v0_o(fb4), .entry_o(ent),
		.wake_o(wak), .sleep_o(slp));
	bmls_top #(.BLANK_LIMIT(BL)) dut (.CLOCK_I(clk), .RST_I(rst),
		.REF_GOOD_I(rg), .VCC_ON_I(von), .FB_ABOVE_REF1_I(fb1),
		.FB_ABOVE_4V0_I(fb4), .BURST_ENTRY_COMPARATOR_I(ent),
		.BURST_WAKE_COMPARATOR_I(wak), .BURST_SLEEP_COMPARATOR_I(slp),
		.TON_LONG_I(ton), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_en),
		.AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata),
		.AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
		.LEVEL_O(lvl_o), .BURST_ENTRY_THRESHOLD_O(thr),
		.CS_LIMIT_SEL_O(cs), .SEL_CURRENT_EN_O(sel),
		.FB_RES_CONNECT_O(fbres), .BIAS_EN_O(bias), .BURST_FLAG_O(flag),
		.COMP_CURVE_O(curve), .IRQ_O(irq));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Clock at 25 MHz
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic results();
		if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// Avalon access held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		addr  <= a;
		wdata <= d;
		wr_en <= w;
		rd_en <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		rv = rdata;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
		if (n >= 50) chk(1, 0);
		@(posedge clk);
	endtask : bus

	task automatic reset_dut();
		rst <= 1'b1;
		cyc(3);
		rst <= 1'b0;
		cyc(1);
	endtask : reset_dut

	// Curve follows the switching time range input
	task automatic t_curve();
		ton <= 1'b1;
		cyc(6);
		chk(curve, 1);
		ton <= 1'b0;
		cyc(6);
		chk(curve, 0);
	endtask : t_curve

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Power-up level pick, select timer, lock, then a burst cycle
	task automatic t_level(input logic [1:0] l, input int mv);
		vcc_mv <= 0;
		reset_dut();
		vcc_mv <= 10000;
		fb_mv  <= mv;
		cyc(8);
		chk({sel, fbres}, 2'h2);
		vcc_mv <= 18000;
		cyc(8);
		chk({lvl_o, thr}, {l, l});
		chk(sel, 1);
		cyc(70);
		chk({sel, fbres}, 2'h1);
		fb_mv <= (l == LVL_1) ? 4500 : 1000;
		cyc(8);
		chk({lvl_o, thr}, {l, l});
		fb_mv <= 1000;
		cyc(BL - 8);
		chk(flag, 0);
		cyc(20);
		chk({flag, bias, cs}, {2'h2, l});
		if (l == LVL_1) t_curve();
		fb_mv <= 3600;
		cyc(8);
		chk({flag, bias}, 2'h3);
		fb_mv <= 3100;
		cyc(8);
		chk({flag, bias}, 2'h2);
		fb_mv <= 4500;
		cyc(8);
		chk({flag, bias, cs}, {2'h1, LIM_FULL});
	endtask : t_level

	// Short dips below the threshold never reach burst
	task automatic t_dip();
		fb_mv <= 1000;
		cyc(BL - 8);
		fb_mv <= 3000;
		cyc(8);
		fb_mv <= 1000;
		cyc(BL - 4);
		chk(flag, 0);
		fb_mv <= 3000;
		cyc(8);
	endtask : t_dip

	// Registers, interrupt mask and clear, enable off
	task automatic t_regs();
		bus(0, OFS_CTRL, 0);
		chk(rv, 32'h1);
		bus(0, OFS_STATUS, 0);
		chk(rv, 32'h17);
		bus(0, OFS_IRQ_ST, 0);
		chk(rv, 32'h7);
		bus(0, 4'h6, 0);
		chk(rv, 32'h0);
		chk(irq, 0);
		bus(1, OFS_IRQ_MK, 32'h1);
		cyc(3);
		chk(irq, 1);
		bus(1, OFS_IRQ_ST, 32'h1);
		cyc(3);
		chk(irq, 0);
		bus(0, OFS_IRQ_ST, 0);
		chk(rv, 32'h6);
		bus(1, OFS_CTRL, 32'h0);
		fb_mv <= 1000;
		cyc(BL + 20);
		chk(flag, 0);
		fb_mv <= 3000;
	endtask : t_regs

	// Reference loss clears the latch and rearms the select source
	task automatic t_refgood();
		vcc_mv <= 5000;
		cyc(8);
		bus(0, OFS_STATUS, 0);
		chk(rv[ST_LATCH], 0);
		vcc_mv <= 10000;
		cyc(8);
		chk({sel, fbres}, 2'h2);
	endtask : t_refgood

	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		{rst, ton, rd_en, wr_en} = 4'h8;
		addr      = 4'h0;
		wdata     = 32'h0;
		fb_mv     = 1000;
		vcc_mv    = 0;
		bad_count = 0;
		tests_run = 0;
		cyc(1);
		reset_dut();
		chk({lvl_o, thr, cs, flag, bias, irq}, {LVL_1, LVL_1, LIM_FULL, 3'h2});
		t_level(LVL_1, 1000);
		t_level(LVL_2, 3000);
		t_level(LVL_3, 4500);
		t_dip();
		t_regs();
		t_curve();
		t_refgood();
		results();
	end
	initial begin
		cyc(20000);
		bad_count++;
		results();
	end
endmodule : bmls_top_tb
